// ===== bench/dms_keypad_model.sv
/*
 * Far-side model: operator keypad keys and drive status sensing.
 * Assumes the bench calls its tasks just after a falling clock edge.
 */
`timescale 1ns/10ps
module dms_keypad_model
    import dms_pkg::*;
(
    input wire logic clk_sys,
    output dms_drive_stat_t drive_stat,
    output logic stop_key,
    output logic alarm_history_clear
);
    logic key_up_dn;
    initial begin
        drive_stat = '0;
        stop_key = 1'b0;
        key_up_dn = 1'b0;
    end
    // Clear setting only reachable with both keys held together
    assign alarm_history_clear = stop_key & key_up_dn;
    // Power stage status; no filter fitted, so carrier lowering allowed
    task automatic set_stat(input logic m1, run, hot, ploss);
        drive_stat = '{m1, run, hot, 1'b0, ploss};
    endtask
    task automatic keys(input logic stp, up);
        stop_key = stp;
        key_up_dn = up;
    endtask
endmodule // dms_keypad_model

// ===== bench/tb_top.sv
/*
 * Self-checking bench for the maintenance supervisor top.
 * Assumes a shortened hour of 20 clocks; inputs move on falling edges.
 */
`timescale 1ns/10ps
module tb_top
    import dms_pkg::*;
;
    logic clk_sys = 1'b0, nrst = 1'b0;
    dms_maint_cfg_t cfg = '0;
    dms_drive_stat_t stat;
    logic [1:0] sso = 2'h0;
    logic [4:0] pmode = 5'h13;
    logic run_cmd = 0, src = 0, link = 0, arst = 0, stp, clr;
    logic ret = 1'b0, rsel = 1'b0, rdbk;
    logic [9:0] wbd = 10'h000;
    logic due, out_a, out_b, tclr, erase, wb, refused, forced;
    logic carrier, ptrip, ope, usel, cap;
    logic [19:0] hours;
    logic [15:0] starts;
    int err_total = 0, comparisons = 0, tcnt = 0, ecnt = 0, rcnt = 0, i;
    initial forever #12.5 clk_sys = ~clk_sys;
    dms_keypad_model i_dms_keypad_model(.clk_sys(clk_sys),
        .drive_stat(stat), .stop_key(stp), .alarm_history_clear(clr));
    dms_top #(.HOUR_CYCLES(20)) i_dms_top(.clk_sys(clk_sys), .nrst(nrst),
        .maint_cfg(cfg), .drive_stat(stat), .output_assign_a(8'h54),
        .output_assign_b(8'h00), .thermal_data_retain_sel(ret),
        .wire_break_delay(wbd), .current_feedback_low(1'b1),
        .current_input_range_sel(rsel), .stop_start_option(sso),
        .run_cmd(run_cmd), .run_source_sel(src),
        .serial_link_enable_cmd(link), .stop_key(stp), .alarm_reset(arst),
        .alarm_history_clear(clr), .protection_mode_bits(pmode),
        .maint_due_output(due), .digital_out_a(out_a), .digital_out_b(out_b),
        .motor1_run_hours(hours), .motor1_startup_counter(starts),
        .thermal_data_clear(tclr), .history_erase(erase),
        .alarm_clear_readback(rdbk), .wire_break_alarm(wb),
        .start_refused(refused), .stop_forced(forced),
        .carrier_lower(carrier), .in_phase_trip(ptrip), .out_phase_en(ope),
        .user_life_sel(usel), .cap_life_en(cap));
    // Pulse outputs last one cycle, so count them on every edge
    always @(posedge clk_sys) begin
        tcnt += int'(tclr === 1'b1);
        ecnt += int'(erase === 1'b1);
        rcnt += int'(rdbk === 1'b1);
    end
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic nclk(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic start_pulse(input logic m1);
        i_dms_keypad_model.set_stat(m1, 1'b1, 1'b0, 1'b0);
        nclk(2);
        i_dms_keypad_model.set_stat(m1, 1'b0, 1'b0, 1'b0);
        nclk(2);
    endtask
    task automatic print_verdict();
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Run takes about 440 cycles; allow over ten times that
    initial begin
        #(25 * 5000);
        err_total++;
        print_verdict();
    end
    initial begin
        nclk(16);
        nrst = 1'b1;
        nclk(6);
        chk(20'(tcnt), 20'h0_0001);
        chk(20'({ope, usel, cap}), 20'h0_0001);
        i_dms_keypad_model.set_stat(1'b1, 1'b0, 1'b1, 1'b1);
        nclk(3);
        chk(20'({carrier, ptrip}), 20'h0_0003);
        pmode = 5'h0C;
        nclk(3);
        chk(20'({carrier, ptrip, ope, usel}), 20'h0_0003);
        chk(20'(wb), 20'h0_0000);
        // Armed delay but zero-based range: low current must not alarm
        wbd = 10'h001;
        rsel = 1'b1;
        nclk(4);
        chk(20'(wb), 20'h0_0000);
        $display("test mode bits done");
        // Run hours: 95 h loaded, interval 10 steps of ten hours
        cfg.interval = 14'h000A;
        cfg.hours_load_val = 20'h0_005F;
        cfg.hours_load = 1'b1;
        nclk(1);
        cfg.hours_load = 1'b0;
        i_dms_keypad_model.set_stat(1'b0, 1'b1, 1'b0, 1'b0);
        nclk(100);
        chk(hours, 20'h0_005F);
        i_dms_keypad_model.set_stat(1'b1, 1'b1, 1'b0, 1'b0);
        for (i = 0; i < 200 && due !== 1'b1; i++) nclk(1);
        chk(hours, 20'h0_0064);
        chk(20'({due, out_a, out_b}), 20'h0_0006);
        cfg.interval_confirm = 1'b1;
        nclk(1);
        cfg.interval_confirm = 1'b0;
        cfg.interval = 14'h0000;
        nclk(2);
        chk(20'(due), 20'h0_0000);
        nclk(150);
        chk(20'(due), 20'h0_0000);
        cfg.hours_load_val = 20'h0_0000;
        cfg.hours_load = 1'b1;
        nclk(1);
        cfg.hours_load = 1'b0;
        i_dms_keypad_model.set_stat(1'b1, 1'b0, 1'b0, 1'b0);
        nclk(1);
        chk(hours, 20'h0_0000);
        $display("test run hours done");
        cfg.start_preset = 16'h0003;
        start_pulse(1'b1);
        start_pulse(1'b1);
        start_pulse(1'b0);
        chk(20'({due, starts}), 20'h0_0002);
        start_pulse(1'b1);
        chk(20'({due, starts}), 20'h1_0003);
        cfg.start_confirm = 1'b1;
        nclk(1);
        cfg.start_confirm = 1'b0;
        nclk(2);
        chk(20'({due, starts}), 20'h0_0000);
        $display("test startups done");
        // Stop key under terminal run, option 0 then option 1
        run_cmd = 1'b1;
        src = 1'b1;
        i_dms_keypad_model.keys(1'b1, 1'b0);
        nclk(3);
        chk(20'(forced), 20'h0_0000);
        sso = 2'h1;
        nclk(3);
        chk(20'(forced), 20'h0_0001);
        i_dms_keypad_model.keys(1'b0, 1'b0);
        run_cmd = 1'b0;
        nclk(3);
        sso = 2'h2;
        run_cmd = 1'b1;
        arst = 1'b1;
        nclk(1);
        arst = 1'b0;
        nclk(3);
        chk(20'(refused), 20'h0_0001);
        run_cmd = 1'b0;
        $display("test start check done");
        i_dms_keypad_model.keys(1'b1, 1'b1);
        nclk(6);
        i_dms_keypad_model.keys(1'b0, 1'b0);
        nclk(2);
        chk(20'(ecnt), 20'h0_0001);
        chk(20'(rcnt), 20'h0_0001);
        $display("test alarm clear done");
        // Second power-on with retention on: no further thermal wipe
        ret = 1'b1;
        nrst = 1'b0;
        nclk(2);
        nrst = 1'b1;
        nclk(4);
        chk(20'(tcnt), 20'h0_0001);
        $display("test thermal retain done");
        print_verdict();
    end
endmodule // tb_top

// ===== hw/dms_pkg.sv
/*
 * Package for the drive maintenance supervisor: field widths, option
 * codes, timing constants and the packed structs that carry settings.
 * Assumes a single 40 MHz system clock.
 */
package dms_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int HOUR_S = 3600;
    // One hour in clock cycles
    localparam longint HOUR_CYC = longint'(CLK_HZ) * HOUR_S;
    localparam int HOURS_PER_STEP = 10;
    // Wire-break delay is set in tenths of a second
    localparam real DELAY_STEP_S = 0.1;
    localparam int DELAY_STEP_CYC = int'(DELAY_STEP_S * CLK_HZ);
    localparam logic [9:0] DELAY_MAX = 10'h0258; // 60.0 s in 0.1 s steps
    localparam logic [13:0] INTERVAL_MAX = 14'h270F; // 9999
    localparam logic [7:0] FUNC_MAINT_DUE = 8'h54; // Output function 84
    localparam logic [1:0] SSO_STOP_PRIO = 2'h1;
    localparam logic [1:0] SSO_START_CHK = 2'h2;
    localparam int PM_CARRIER = 0;
    localparam int PM_IN_PHASE = 1;
    localparam int PM_OUT_PHASE = 2;
    localparam int PM_USER_LIFE = 3;
    localparam int PM_CAP_LIFE = 4;
    localparam logic [4:0] PM_RESET = 5'h13; // 19: bits 0, 1, 4
    localparam logic [19:0] RUN_HOURS_W0 = 20'h0_0000;
    localparam logic [15:0] STARTS_W0 = 16'h0000;

    // Maintenance settings written by the operator
    typedef struct packed {
        logic [13:0] interval;      // Tens of hours, 0 disables
        logic interval_confirm;     // Pulse: new interval confirmed
        logic [15:0] start_preset;  // 0 disables
        logic start_confirm;        // Pulse: new preset confirmed
        logic [19:0] hours_load_val;
        logic hours_load;           // Pulse: load run-hour counter
        logic [15:0] starts_load_val;
        logic starts_load;          // Pulse: load startup counter
    } dms_maint_cfg_t;

    // Drive status sensed from the power stage
    typedef struct packed {
        logic motor1_sel;       // Output drives motor 1
        logic running;          // Output active
        logic heatsink_hot;
        logic overload;
        logic in_phase_loss;
    } dms_drive_stat_t;
endpackage

// ===== hw/dms_start_check.sv
/*
 * Start interlock: stop-key priority and start check. Assumes the run
 * command and trigger events are synchronous single-cycle or levels.
 */
`timescale 1ns/10ps
module dms_start_check
    import dms_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [1:0] option,
    input wire logic run_cmd,
    input wire logic remote_src,
    input wire logic stop_key,
    input wire logic alarm_reset,
    input wire logic link_switch,
    output logic start_block,
    output logic stop_forced
);
    logic por_reg;
    logic check_evt;
    logic stop_en;
    logic chk_en;

    // Decoded option bits
    assign stop_en = (option & SSO_STOP_PRIO) != 2'h0;
    assign chk_en = (option & SSO_START_CHK) != 2'h0;

    // First cycle after reset release counts as power-on
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            por_reg <= 1'b1;
        end else begin
            por_reg <= 1'b0;
        end
    end

    assign check_evt = por_reg || alarm_reset || link_switch;

    // Refusal latches until the run command drops
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            start_block <= 1'b0;
        end else if (chk_en && check_evt && run_cmd) begin
            start_block <= 1'b1;
        end else if (!run_cmd) begin
            start_block <= 1'b0;
        end
    end

    // Stop key overrides remote run until the command is withdrawn
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            stop_forced <= 1'b0;
        end else if (stop_en && stop_key && remote_src && run_cmd) begin
            stop_forced <= 1'b1;
        end else if (!run_cmd) begin
            stop_forced <= 1'b0;
        end
    end

    chk_start_refuse: assert property (@(posedge clk_sys)
        disable iff (!nrst) (chk_en && alarm_reset && run_cmd) |=> start_block)
        else $error("start check did not refuse");
    chk_stop_prio: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        (stop_en && stop_key && remote_src && run_cmd) |=> stop_forced)
        else $error("stop key did not force stop");
    chk_stop_off: assert property (@(posedge clk_sys)
        disable iff (!nrst) (!stop_en && !stop_forced) |=> !$rose(stop_forced))
        else $error("stop forced while priority disabled");
endmodule // dms_start_check

// ===== hw/dms_top.sv
/*
 * Drive maintenance supervisor top: motor-1 run-hour and startup
 * maintenance counters, due output routing, thermal data retention,
 * alarm history clear and protection mode decoding.
 * Assumes all inputs synchronous to clk_sys; settings held stable.
 */
`timescale 1ns/10ps
module dms_top
    import dms_pkg::*;
#(
    parameter longint HOUR_CYCLES = HOUR_CYC
)
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire dms_maint_cfg_t maint_cfg,
    input wire dms_drive_stat_t drive_stat,
    input wire logic [7:0] output_assign_a,
    input wire logic [7:0] output_assign_b,
    input wire logic thermal_data_retain_sel,
    input wire logic [9:0] wire_break_delay,
    input wire logic current_feedback_low,
    input wire logic current_input_range_sel,
    input wire logic [1:0] stop_start_option,
    input wire logic run_cmd,
    input wire logic run_source_sel,
    input wire logic serial_link_enable_cmd,
    input wire logic stop_key,
    input wire logic alarm_reset,
    input wire logic alarm_history_clear,
    input wire logic [4:0] protection_mode_bits,
    output logic maint_due_output,
    output logic digital_out_a,
    output logic digital_out_b,
    output logic [19:0] motor1_run_hours,
    output logic [15:0] motor1_startup_counter,
    output logic thermal_data_clear,
    output logic history_erase,
    output logic alarm_clear_readback,
    output logic wire_break_alarm,
    output logic start_refused,
    output logic stop_forced,
    output logic carrier_lower,
    output logic in_phase_trip,
    output logic out_phase_en,
    output logic user_life_sel,
    output logic cap_life_en
);
    logic [41:0] hour_div_reg;
    logic hour_tick;
    logic [3:0] sub_hours_reg;
    logic [31:0] step_div_reg;
    logic step_tick;
    logic run_prev_reg;
    logic hours_due_reg;
    logic starts_due_reg;
    logic hours_hit;
    logic starts_hit;
    logic por_reg;
    logic link_prev_reg;
    logic clr_prev_reg;
    logic wb_alarm;
    logic blk;
    logic stp;
    logic [19:0] interval_hours;

    // Interval in hours, ten-hour granularity
    assign interval_hours = maint_cfg.interval * 20'(HOURS_PER_STEP);

    // Hour divider runs only while motor 1 is driven
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            hour_div_reg <= 42'h000_0000_0000;
        end else if (maint_cfg.hours_load) begin
            hour_div_reg <= 42'h000_0000_0000;
        end else if (drive_stat.running && drive_stat.motor1_sel) begin
            if (hour_div_reg == 42'(HOUR_CYCLES - 1)) begin
                hour_div_reg <= 42'h000_0000_0000;
            end else begin
                hour_div_reg <= hour_div_reg + 42'h000_0000_0001;
            end
        end
    end
    assign hour_tick = drive_stat.running && drive_stat.motor1_sel
        && hour_div_reg == 42'(HOUR_CYCLES - 1);

    // Run-hour counter; direct load has priority over counting
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            motor1_run_hours <= RUN_HOURS_W0;
        end else if (maint_cfg.hours_load) begin
            motor1_run_hours <= maint_cfg.hours_load_val;
        end else if (maint_cfg.interval_confirm) begin
            motor1_run_hours <= RUN_HOURS_W0;
        end else if (hour_tick && !hours_due_reg
                     && motor1_run_hours != 20'hF_FFFF) begin
            motor1_run_hours <= motor1_run_hours + 20'h0_0001;
        end
    end

    // Tracks hours within the current ten-hour step, for display only
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sub_hours_reg <= 4'h0;
        end else if (hour_tick) begin
            sub_hours_reg <= (sub_hours_reg == 4'(HOURS_PER_STEP - 1))
                ? 4'h0 : sub_hours_reg + 4'h1;
        end
    end

    assign hours_hit = maint_cfg.interval != 14'h0000
        && maint_cfg.interval <= INTERVAL_MAX
        && motor1_run_hours >= interval_hours;

    // Run-time due flag; confirm wins over a new hit
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            hours_due_reg <= 1'b0;
        end else if (hours_hit && !maint_cfg.interval_confirm) begin
            hours_due_reg <= 1'b1;
        end else if (maint_cfg.interval_confirm) begin
            hours_due_reg <= 1'b0;
        end
    end

    // Startup counter counts run rising edges on motor 1
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            run_prev_reg <= 1'b0;
        end else begin
            run_prev_reg <= drive_stat.running;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            motor1_startup_counter <= STARTS_W0;
        end else if (maint_cfg.starts_load) begin
            motor1_startup_counter <= maint_cfg.starts_load_val;
        end else if (maint_cfg.start_confirm) begin
            motor1_startup_counter <= STARTS_W0;
        end else if (drive_stat.running && !run_prev_reg
                     && drive_stat.motor1_sel && !starts_due_reg
                     && motor1_startup_counter != 16'hFFFF) begin
            motor1_startup_counter <= motor1_startup_counter + 16'h0001;
        end
    end

    assign starts_hit = maint_cfg.start_preset != 16'h0000
        && motor1_startup_counter >= maint_cfg.start_preset;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            starts_due_reg <= 1'b0;
        end else if (starts_hit && !maint_cfg.start_confirm) begin
            starts_due_reg <= 1'b1;
        end else if (maint_cfg.start_confirm) begin
            starts_due_reg <= 1'b0;
        end
    end

    // Due signal and routing to outputs assigned function 84
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            maint_due_output <= 1'b0;
            digital_out_a <= 1'b0;
            digital_out_b <= 1'b0;
        end else begin
            maint_due_output <= hours_due_reg || starts_due_reg;
            digital_out_a <= (hours_due_reg || starts_due_reg)
                && output_assign_a == FUNC_MAINT_DUE;
            digital_out_b <= (hours_due_reg || starts_due_reg)
                && output_assign_b == FUNC_MAINT_DUE;
        end
    end

    // Power-on marker for one cycle after reset release
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            por_reg <= 1'b1;
        end else begin
            por_reg <= 1'b0;
        end
    end

    // Thermal model wiped only at power-on when retention is off
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            thermal_data_clear <= 1'b0;
        end else begin
            thermal_data_clear <= por_reg && !thermal_data_retain_sel;
        end
    end

    // Clear setting edge; a held setting must not erase again and again
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            clr_prev_reg <= 1'b0;
        end else begin
            clr_prev_reg <= alarm_history_clear;
        end
    end

    // Clear request: one erase pulse, setting reads back 0 afterwards
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            history_erase <= 1'b0;
            alarm_clear_readback <= 1'b0;
        end else begin
            history_erase <= alarm_history_clear && !clr_prev_reg;
            alarm_clear_readback <= alarm_history_clear
                && !clr_prev_reg;
        end
    end

    // 0.1 s enable for the wire-break timer
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            step_div_reg <= 32'h0000_0000;
        end else if (step_div_reg == 32'(DELAY_STEP_CYC - 1)) begin
            step_div_reg <= 32'h0000_0000;
        end else begin
            step_div_reg <= step_div_reg + 32'h0000_0001;
        end
    end
    assign step_tick = step_div_reg == 32'(DELAY_STEP_CYC - 1);

    dms_wire_break u_wire_break (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .tick(step_tick),
        .below_thr(current_feedback_low),
        .zero_based_range(current_input_range_sel),
        .delay_set(wire_break_delay > DELAY_MAX ? DELAY_MAX : wire_break_delay),
        .alarm(wb_alarm)
    );

    // Rising edge of link enable is a source switch to the serial link
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            link_prev_reg <= 1'b0;
        end else begin
            link_prev_reg <= serial_link_enable_cmd;
        end
    end

    dms_start_check u_start_check (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .option(stop_start_option),
        .run_cmd(run_cmd),
        .remote_src(run_source_sel || serial_link_enable_cmd),
        .stop_key(stop_key),
        .alarm_reset(alarm_reset),
        .link_switch(serial_link_enable_cmd && !link_prev_reg),
        .start_block(blk),
        .stop_forced(stp)
    );

    // Registered status and protection decode
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wire_break_alarm <= 1'b0;
            start_refused <= 1'b0;
            stop_forced <= 1'b0;
            carrier_lower <= 1'b0;
            in_phase_trip <= 1'b0;
            out_phase_en <= 1'b0;
            user_life_sel <= 1'b0;
            cap_life_en <= 1'b0;
        end else begin
            wire_break_alarm <= wb_alarm;
            start_refused <= blk;
            stop_forced <= stp;
            carrier_lower <= protection_mode_bits[PM_CARRIER]
                && (drive_stat.heatsink_hot || drive_stat.overload);
            in_phase_trip <= protection_mode_bits[PM_IN_PHASE]
                && drive_stat.in_phase_loss;
            out_phase_en <= protection_mode_bits[PM_OUT_PHASE];
            user_life_sel <= protection_mode_bits[PM_USER_LIFE];
            cap_life_en <= protection_mode_bits[PM_CAP_LIFE];
        end
    end

    chk_hours_due: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        (hours_hit && !maint_cfg.interval_confirm) |=> ##1 maint_due_output)
        else $error("run-hour hit did not raise due");
    chk_interval_zero: assert property (@(posedge clk_sys)
        disable iff (!nrst) maint_cfg.interval == 14'h0000 |-> !hours_hit)
        else $error("zero interval compared");
    chk_hours_load: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        maint_cfg.hours_load |=> motor1_run_hours == $past(maint_cfg.hours_load_val))
        else $error("run-hour load lost");
    chk_confirm_clear: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        (maint_cfg.interval_confirm && !starts_due_reg && !maint_cfg.hours_load)
        |=> !hours_due_reg && motor1_run_hours == RUN_HOURS_W0)
        else $error("interval confirm did not restart");
    chk_motor2_hold: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        (!drive_stat.motor1_sel && !maint_cfg.hours_load
         && !maint_cfg.interval_confirm) |=> $stable(motor1_run_hours))
        else $error("run hours moved on motor 2");
    chk_start_due: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        (starts_hit && !maint_cfg.start_confirm) |=> ##1 maint_due_output)
        else $error("startup hit did not raise due");
    chk_thermal_keep: assert property (@(posedge clk_sys)
        disable iff (!nrst) thermal_data_retain_sel |=> !thermal_data_clear)
        else $error("thermal data cleared while retained");
    chk_clear_pulse: assert property (@(posedge clk_sys)
        disable iff (!nrst) history_erase |=> !history_erase)
        else $error("history erase longer than one cycle");
    chk_carrier_off: assert property (@(posedge clk_sys)
        disable iff (!nrst) !protection_mode_bits[PM_CARRIER] |=> !carrier_lower)
        else $error("carrier lowered while disabled");
endmodule // dms_top

// ===== hw/dms_wire_break.sv
/*
 * Feedback wire-break timer. Counts 0.1 s ticks while the loop current
 * sits below threshold. Assumes the below-threshold flag is synchronous.
 */
`timescale 1ns/10ps
module dms_wire_break
    import dms_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic tick,
    input wire logic below_thr,
    input wire logic zero_based_range,
    input wire logic [9:0] delay_set,
    output logic alarm
);
    logic [9:0] cnt_reg;
    logic armed;

    // Zero delay or a 0-20 mA range switches detection off
    assign armed = (delay_set != 10'h000) && !zero_based_range;

    // Persistence counter in delay steps
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= 10'h000;
        end else if (!armed || !below_thr) begin
            cnt_reg <= 10'h000;
        end else if (tick && cnt_reg < delay_set) begin
            cnt_reg <= cnt_reg + 10'h001;
        end
    end

    // Alarm holds while the break persists past the delay
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            alarm <= 1'b0;
        end else begin
            alarm <= armed && below_thr && cnt_reg >= delay_set;
        end
    end

    chk_break_off_range: assert property (@(posedge clk_sys)
        disable iff (!nrst) zero_based_range |=> !alarm)
        else $error("wire-break alarm with zero-based range");
    chk_break_needs_low: assert property (@(posedge clk_sys)
        disable iff (!nrst) alarm |-> $past(below_thr))
        else $error("wire-break alarm without low current");
endmodule // dms_wire_break
